// ===== src/sbc_regs_pkg.sv
// Purpose: constants for the status register bank
// Assumes: 16-bit frames, address in frame bits 6:0, access mode in bit 7
// Notes: all offsets are 7-bit register addresses
package sbc_regs_pkg;
    localparam logic [6:0] ADDR_CYCLIC_TIMER_PERIOD = 7'h0c;
    localparam logic [6:0] ADDR_SCRATCH_CONFIG_BYTE = 7'h1e;
    localparam logic [6:0] ADDR_SUPPLY_FAULT_STATUS = 7'h41;
    localparam logic [6:0] ADDR_THERMAL_STATUS = 7'h42;
    localparam logic [6:0] ADDR_DEVICE_FAILURE_STATUS = 7'h43;

    localparam int FRAME_BITS = 16;
    localparam int MODE_BIT = 7;
    localparam int DATA_LSB = 8;

    localparam logic [2:0] PERIOD_RESET = 3'h0;
    localparam logic [2:0] PERIOD_RESERVED = 3'h7;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;

    // supply fault byte layout
    localparam int SUP_POR_BIT = 7;
    localparam int SUP_LIN_UV_BIT = 6;
    localparam int SUP_MAIN_OV_BIT = 5;
    localparam int SUP_SEC_OT_BIT = 4;
    localparam int SUP_SEC_UV_BIT = 3;
    localparam int SUP_MAIN_SC_BIT = 2;
    localparam int SUP_MAIN_UV_BIT = 0;
    localparam logic [7:0] SUP_CLEAR_MASK = 8'hfd;

    // thermal byte layout
    localparam int TH_SEVERE_BIT = 2;
    localparam int TH_MODERATE_BIT = 1;
    localparam int TH_PREWARN_BIT = 0;
    localparam logic [7:0] TH_CLEAR_MASK = 8'h07;

    // device byte layout
    localparam int DEV_PREV_MSB = 7;
    localparam int DEV_PREV_LSB = 6;
    localparam int DEV_CLAMP_BIT = 5;
    localparam int DEV_FSI_BIT = 4;
    localparam int DEV_WDC_MSB = 3;
    localparam int DEV_WDC_LSB = 2;
    localparam int DEV_SPI_BIT = 1;
    localparam int DEV_FO_BIT = 0;

    localparam logic [1:0] PREV_CLEARED = 2'h0;
    localparam logic [1:0] PREV_RESTART = 2'h1;
    localparam logic [1:0] PREV_SLEEP_WAKE = 2'h2;
    localparam logic [1:0] WDC_ZERO = 2'h0;
    localparam logic [1:0] WDC_ONE = 2'h1;
    localparam logic [1:0] WDC_TWO = 2'h2;
endpackage : sbc_regs_pkg

// ===== src/sbc_sync2.sv
// Purpose: two-flop synchroniser for a bundle of asynchronous levels
// Assumes: inputs are slow levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sbc_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_type;

    sync_state_type st_r;
    sync_state_type st_nxt;

    always_comb begin
        st_nxt.meta = i_async;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync;
endmodule : sbc_sync2
`default_nettype wire

// ===== src/sbc_frame_rx.sv
// Purpose: shift in one 16-bit frame
// Assumes: mode 0 framing, data captured on rising serial clock, msb first
// Notes: serial pins are sampled by i_mclk; link clock slower than 8 cycles
`timescale 1ns/1ps
`default_nettype none
module sbc_frame_rx (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // serial pins
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdi,
    // frame out
    output logic o_frame_valid,
    output logic o_frame_bad,
    output logic [15:0] o_frame,
    // select edge, for reply loading
    output logic o_select_start,
    output logic o_sclk_fall,
    output logic o_selected
);
    typedef struct packed {
        logic sclk_d;
        logic csn_d;
        logic [15:0] shreg;
        logic [4:0] count;
        logic valid;
        logic bad;
        logic [15:0] frame;
    } rx_state_type;

    rx_state_type st_r;
    rx_state_type st_nxt;
    logic [2:0] pins_s;
    logic sclk_s;
    logic csn_s;
    logic sdi_s;

    sbc_sync2 #(.WIDTH(3)) u_pin_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        // inverted: the sync reset state reads as deselected
        .i_async({i_sclk, ~i_csn, i_sdi}),
        .o_sync(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign csn_s = ~pins_s[1];
    assign sdi_s = pins_s[0];

    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_d = sclk_s;
        st_nxt.csn_d = csn_s;
        st_nxt.valid = 1'b0;
        st_nxt.bad = 1'b0;
        if (st_r.csn_d && !csn_s) begin
            st_nxt.count = '0;
        end
        if (!csn_s && sclk_s && !st_r.sclk_d) begin
            st_nxt.shreg = {st_r.shreg[14:0], sdi_s};
            if (st_r.count != 5'h1f) begin
                st_nxt.count = st_r.count + 5'h01;
            end
        end
        // a frame of any other length is an invalid command
        if (!st_r.csn_d && csn_s) begin
            if (st_r.count == 5'h10) begin
                st_nxt.valid = 1'b1;
                st_nxt.frame = st_r.shreg;
            end else begin
                st_nxt.bad = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_r <= '{sclk_d: 1'b0, csn_d: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_frame_valid = st_r.valid;
    assign o_frame_bad = st_r.bad;
    assign o_frame = st_r.frame;
    assign o_select_start = st_r.csn_d & ~csn_s;
    assign o_sclk_fall = ~csn_s & ~sclk_s & st_r.sclk_d;
    assign o_selected = ~csn_s;
endmodule : sbc_frame_rx
`default_nettype wire

// ===== src/sbc_status_register_bank.sv
// Purpose: register group reached by 16-bit frames
// Assumes: event inputs are asynchronous levels; mode inputs are levels
// Notes: reply shifts out the addressed byte during the next frame
//
// Operation
// RULE_01: 3-bit cyclic period selector, reset zero
// RULE_02: reserved bits read zero, ignore writes
// RULE_03: scratch byte, read/write, unused internally
// RULE_04: scratch byte cleared only by power-on
// RULE_05: scratch writable in normal and stop mode
// RULE_06: 16-bit frame; status data byte ignored
// RULE_07: mode bit zero reads status unchanged
// RULE_08: mode bit one clears status byte
// RULE_09: data bits map to frame bits 8-15
// RULE_10: status flags stick until cleared
// RULE_11: supply fault byte bit layout
// RULE_12: main regulator off blocks short, undervoltage
// RULE_13: second regulator off blocks its flags
// RULE_14: all LINs wake/off blocks LIN undervoltage
// RULE_15: thermal byte layout; severe enters fail-safe
// RULE_16: previous-state field codes in bits 7:6
// RULE_17: reset pin clamped high sets bit 5
// RULE_18: fail-safe input pattern error sets bit 4
// RULE_19: watchdog failure counter, hardware-updated
// RULE_20: invalid command sets bit 1, not executed
// RULE_21: fail outputs active sets bit 0
// RULE_22: good watchdog trigger zeroes failure counter
// RULE_23: hardware set beats simultaneous clear
`timescale 1ns/1ps
`default_nettype none
module sbc_status_register_bank (
    // clock and resets
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_soft_reset,
    input wire logic i_restart,
    // serial link pins
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    // chip mode and supply state
    input wire logic i_normal_mode,
    input wire logic i_stop_mode,
    input wire logic i_main_reg_on,
    input wire logic i_second_reg_on,
    input wire logic i_lins_quiet,
    input wire logic i_wake_from_sleep,
    // hardware events
    input wire logic i_power_on_event,
    input wire logic i_lin_supply_uv,
    input wire logic i_main_reg_ov,
    input wire logic i_second_reg_ot,
    input wire logic i_second_reg_uv,
    input wire logic i_main_reg_short,
    input wire logic i_main_reg_uv,
    input wire logic i_severe_thermal,
    input wire logic i_moderate_thermal,
    input wire logic i_thermal_prewarn,
    input wire logic i_reset_pin_clamped,
    input wire logic i_failsafe_input_error,
    input wire logic i_watchdog_fail,
    input wire logic i_watchdog_trigger_ok,
    input wire logic i_fail_outputs_on,
    // configuration and mode outputs
    output logic [2:0] o_cyclic_period_select,
    output logic o_enter_failsafe,
    output logic [1:0] o_fail_output_config
);
    typedef struct packed {
        logic [2:0] cyclic_period_select;
        logic [7:0] scratch_byte_field;
        logic [7:0] supply_fault;
        logic [2:0] thermal;
        logic [1:0] previous_state_field;
        logic reset_pin_clamped_flag;
        logic failsafe_input_error_flag;
        logic [1:0] watchdog_failure_counter;
        logic spi_invalid_flag;
        logic fail_outputs_active_flag;
        logic watchdog_failure_counter_d;
        logic [7:0] reply;
        logic [15:0] out_shreg;
        logic sdo;
        logic sdo_oe;
        logic enter_failsafe;
        logic [1:0] fo_config;
    } bank_state_type;

    bank_state_type st_r;
    bank_state_type st_nxt;

    logic [18:0] ev_s;
    logic frame_valid;
    logic frame_bad;
    logic [15:0] frame;
    logic select_start;
    logic sclk_fall;
    logic selected;
    logic [6:0] addr;
    logic clear_mode;
    logic [7:0] wdata;
    logic known_addr;
    logic [7:0] sup_set;
    logic [2:0] th_set;
    logic soft_rst_s;
    logic restart_s;
    logic watchdog_failure_counter_s;
    logic wd_ok_s;

    // supply levels and most events cross in through two flops; mode, wake and fail-output inputs are used directly
    sbc_sync2 #(.WIDTH(19)) u_event_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async({i_soft_reset, i_restart, i_main_reg_on, i_second_reg_on,
                  i_lins_quiet, i_power_on_event, i_lin_supply_uv,
                  i_main_reg_ov, i_second_reg_ot, i_second_reg_uv,
                  i_main_reg_short, i_main_reg_uv, i_severe_thermal,
                  i_moderate_thermal, i_thermal_prewarn,
                  i_reset_pin_clamped, i_failsafe_input_error,
                  i_watchdog_fail, i_watchdog_trigger_ok}),
        .o_sync(ev_s)
    );

    sbc_frame_rx u_frame_rx (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_sclk(i_sclk),
        .i_csn(i_csn),
        .i_sdi(i_sdi),
        .o_frame_valid(frame_valid),
        .o_frame_bad(frame_bad),
        .o_frame(frame),
        .o_select_start(select_start),
        .o_sclk_fall(sclk_fall),
        .o_selected(selected)
    );

    assign soft_rst_s = ev_s[18];
    assign restart_s = ev_s[17];
    assign watchdog_failure_counter_s = ev_s[1];
    assign wd_ok_s = ev_s[0];

    // frame fields: address low, mode bit 7, data in bits 15:8
    assign addr = frame[6:0]; // RULE_06
    assign clear_mode = frame[sbc_regs_pkg::MODE_BIT];
    assign wdata = frame[15:sbc_regs_pkg::DATA_LSB]; // RULE_09

    always_comb begin
        unique case (addr)
            sbc_regs_pkg::ADDR_CYCLIC_TIMER_PERIOD,
            sbc_regs_pkg::ADDR_SCRATCH_CONFIG_BYTE,
            sbc_regs_pkg::ADDR_SUPPLY_FAULT_STATUS,
            sbc_regs_pkg::ADDR_THERMAL_STATUS,
            sbc_regs_pkg::ADDR_DEVICE_FAILURE_STATUS: known_addr = 1'b1;
            default: known_addr = 1'b0;
        endcase
    end

    // event sets; main short/undervoltage and second-regulator flags suppressed while that regulator is off, LIN undervoltage while LINs quiet
    always_comb begin
        sup_set = '0;
        sup_set[sbc_regs_pkg::SUP_POR_BIT] = ev_s[13];
        sup_set[sbc_regs_pkg::SUP_LIN_UV_BIT] = ev_s[12] & ~ev_s[14]; // RULE_14
        sup_set[sbc_regs_pkg::SUP_MAIN_OV_BIT] = ev_s[11];
        sup_set[sbc_regs_pkg::SUP_SEC_OT_BIT] = ev_s[10] & ev_s[15]; // RULE_13
        sup_set[sbc_regs_pkg::SUP_SEC_UV_BIT] = ev_s[9] & ev_s[15]; // RULE_13
        sup_set[sbc_regs_pkg::SUP_MAIN_SC_BIT] = ev_s[8] & ev_s[16]; // RULE_12
        sup_set[sbc_regs_pkg::SUP_MAIN_UV_BIT] = ev_s[7] & ev_s[16]; // RULE_12
        th_set = {ev_s[6], ev_s[5], ev_s[4]}; // RULE_15
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.watchdog_failure_counter_d = watchdog_failure_counter_s;

        // register writes and clears, only on a well-formed frame
        if (frame_valid && known_addr) begin
            unique case (addr)
                sbc_regs_pkg::ADDR_CYCLIC_TIMER_PERIOD: begin
                    // reserved code and bits 7:3 are dropped
                    if (clear_mode &&
                        wdata[2:0] != sbc_regs_pkg::PERIOD_RESERVED) begin
                        st_nxt.cyclic_period_select = wdata[2:0]; // RULE_01 RULE_02
                    end
                end
                sbc_regs_pkg::ADDR_SCRATCH_CONFIG_BYTE: begin
                    if (clear_mode && (i_normal_mode || i_stop_mode)) begin
                        st_nxt.scratch_byte_field = wdata; // RULE_03 RULE_05
                    end
                end
                sbc_regs_pkg::ADDR_SUPPLY_FAULT_STATUS: begin
                    if (clear_mode) begin
                        st_nxt.supply_fault = '0; // RULE_08
                    end
                end
                sbc_regs_pkg::ADDR_THERMAL_STATUS: begin
                    if (clear_mode) begin
                        st_nxt.thermal = '0; // RULE_08
                    end
                end
                sbc_regs_pkg::ADDR_DEVICE_FAILURE_STATUS: begin
                    // counter is hardware owned and survives the clear
                    if (clear_mode) begin
                        st_nxt.previous_state_field = sbc_regs_pkg::PREV_CLEARED;
                        st_nxt.reset_pin_clamped_flag = 1'b0;
                        st_nxt.failsafe_input_error_flag = 1'b0;
                        st_nxt.spi_invalid_flag = 1'b0;
                        st_nxt.fail_outputs_active_flag = 1'b0; // RULE_08
                    end
                end
                default: begin
                end
            endcase
        end

        // sets come after clears so a simultaneous event wins
        st_nxt.supply_fault = (st_nxt.supply_fault | sup_set)
                              & sbc_regs_pkg::SUP_CLEAR_MASK; // RULE_10 RULE_11 RULE_23
        st_nxt.thermal = st_nxt.thermal | th_set; // RULE_10 RULE_23
        if (ev_s[3]) begin
            st_nxt.reset_pin_clamped_flag = 1'b1; // RULE_17 RULE_23
        end
        if (ev_s[2]) begin
            st_nxt.failsafe_input_error_flag = 1'b1; // RULE_18 RULE_23
        end
        if (frame_bad || (frame_valid && !known_addr)) begin
            st_nxt.spi_invalid_flag = 1'b1; // RULE_20 RULE_23
        end
        if (i_fail_outputs_on) begin
            st_nxt.fail_outputs_active_flag = 1'b1; // RULE_21 RULE_23
        end
        if (restart_s) begin
            st_nxt.previous_state_field = sbc_regs_pkg::PREV_RESTART; // RULE_16
        end else if (i_wake_from_sleep) begin
            st_nxt.previous_state_field = sbc_regs_pkg::PREV_SLEEP_WAKE; // RULE_16
        end

        // counter saturates at two; the unused code is never reached
        if (wd_ok_s) begin
            st_nxt.watchdog_failure_counter = sbc_regs_pkg::WDC_ZERO; // RULE_22
        end else if (watchdog_failure_counter_s && !st_r.watchdog_failure_counter_d &&
                     st_r.watchdog_failure_counter != sbc_regs_pkg::WDC_TWO) begin
            st_nxt.watchdog_failure_counter =
                st_r.watchdog_failure_counter + 2'h1; // RULE_19
        end
        unique case (st_nxt.watchdog_failure_counter)
            sbc_regs_pkg::WDC_ONE: st_nxt.fo_config = 2'h1; // RULE_19
            sbc_regs_pkg::WDC_TWO: st_nxt.fo_config = 2'h3; // RULE_19
            default: st_nxt.fo_config = 2'h0;
        endcase
        st_nxt.enter_failsafe = th_set[sbc_regs_pkg::TH_SEVERE_BIT]; // RULE_15

        // reply byte is captured from the state seen by this frame
        if (frame_valid) begin
            unique case (addr)
                sbc_regs_pkg::ADDR_CYCLIC_TIMER_PERIOD:
                    st_nxt.reply = {5'h00, st_r.cyclic_period_select}; // RULE_02
                sbc_regs_pkg::ADDR_SCRATCH_CONFIG_BYTE:
                    st_nxt.reply = st_r.scratch_byte_field;
                sbc_regs_pkg::ADDR_SUPPLY_FAULT_STATUS:
                    st_nxt.reply = st_r.supply_fault; // RULE_07
                sbc_regs_pkg::ADDR_THERMAL_STATUS:
                    st_nxt.reply = {5'h00, st_r.thermal}; // RULE_07
                sbc_regs_pkg::ADDR_DEVICE_FAILURE_STATUS:
                    st_nxt.reply = {st_r.previous_state_field,
                                    st_r.reset_pin_clamped_flag,
                                    st_r.failsafe_input_error_flag,
                                    st_r.watchdog_failure_counter,
                                    st_r.spi_invalid_flag,
                                    st_r.fail_outputs_active_flag}; // RULE_07
                default: st_nxt.reply = 8'h00;
            endcase
        end

        // out shift: reply byte first then supply fault byte, msb first
        st_nxt.sdo_oe = selected;
        if (select_start) begin
            st_nxt.out_shreg = {st_r.reply, st_r.supply_fault}; // RULE_09
            st_nxt.sdo = st_r.reply[7];
        end else if (sclk_fall) begin
            st_nxt.out_shreg = {st_r.out_shreg[14:0], 1'b0};
            st_nxt.sdo = st_r.out_shreg[14];
        end

        // soft reset reloads period, thermal, previous state and watchdog counter; scratch byte kept
        if (soft_rst_s) begin
            st_nxt.cyclic_period_select = sbc_regs_pkg::PERIOD_RESET; // RULE_01
            st_nxt.thermal = '0;
            st_nxt.previous_state_field = sbc_regs_pkg::PREV_CLEARED;
            st_nxt.watchdog_failure_counter = sbc_regs_pkg::WDC_ZERO;
            st_nxt.scratch_byte_field = st_r.scratch_byte_field; // RULE_04
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_r <= '0;
            st_r.scratch_byte_field <= sbc_regs_pkg::SCRATCH_RESET; // RULE_04
            st_r.supply_fault <= 8'h80;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sdo = st_r.sdo;
    assign o_sdo_oe = st_r.sdo_oe;
    assign o_cyclic_period_select = st_r.cyclic_period_select;
    assign o_enter_failsafe = st_r.enter_failsafe;
    assign o_fail_output_config = st_r.fo_config;
endmodule : sbc_status_register_bank
`default_nettype wire

// ===== verif/sbc_status_register_bank_properties.sv
// Purpose: port checks
// Assumes: soft reset only while link idle
// Notes: two-flop sync on events, so six-cycle spans
`timescale 1ns/1ps
`default_nettype none
module sbc_status_register_bank_properties (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // inputs
    input wire logic i_csn,
    input wire logic i_severe_thermal,
    input wire logic i_watchdog_fail,
    input wire logic i_watchdog_trigger_ok,
    // outputs
    input wire logic [2:0] o_cyclic_period_select,
    input wire logic o_enter_failsafe,
    input wire logic [1:0] o_fail_output_config
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_period_legal;
        o_cyclic_period_select != 3'h7;
    endproperty
    a_period_legal: assert property (p_period_legal)
        else $error("reserved period");
    property p_period_idle;
        $changed(o_cyclic_period_select) |-> i_csn;
    endproperty
    a_period_idle: assert property (p_period_idle)
        else $error("period moved in frame");
    property p_cfg_legal;
        o_fail_output_config != 2'h2;
    endproperty
    a_cfg_legal: assert property (p_cfg_legal)
        else $error("bad fail config");
    property p_fs_on;
        i_severe_thermal [*6] |-> o_enter_failsafe;
    endproperty
    a_fs_on: assert property (p_fs_on)
        else $error("no fail-safe");
    property p_fs_off;
        !i_severe_thermal [*6] |-> !o_enter_failsafe;
    endproperty
    a_fs_off: assert property (p_fs_off)
        else $error("stray fail-safe");
    property p_wd_one;
        $rose(i_watchdog_fail) && o_fail_output_config == 2'h0
            && !i_watchdog_trigger_ok |-> ##[1:8] o_fail_output_config == 2'h1;
    endproperty
    a_wd_one: assert property (p_wd_one)
        else $error("no config 1");
    property p_wd_two;
        $rose(i_watchdog_fail) && o_fail_output_config == 2'h1
            && !i_watchdog_trigger_ok |-> ##[1:8] o_fail_output_config == 2'h3;
    endproperty
    a_wd_two: assert property (p_wd_two)
        else $error("no config 3");
    property p_trig_ok;
        i_watchdog_trigger_ok [*6] |-> o_fail_output_config == 2'h0;
    endproperty
    a_trig_ok: assert property (p_trig_ok)
        else $error("count not zeroed");
    c_frame: cover property ($rose(i_csn));
    c_failsafe: cover property ($rose(o_enter_failsafe));
    c_cfg3: cover property (o_fail_output_config == 2'h3);
endmodule : sbc_status_register_bank_properties
`default_nettype wire

// ===== verif/sbc_spi_master_model.sv
// Purpose: link master
// Assumes: mode 0, msb first, 48 ns link clock period
// Notes: clock idles low; data toggles between frames
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_master_model (
    // link pins
    output logic o_sclk,
    output logic o_csn,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial {o_sclk, o_csn, o_sdi} = 3'h2;
    task automatic xfer(input int n, input logic [15:0] tx,
                        output logic [15:0] rx);
        rx = 16'h0000;
        o_csn = 1'b0;
        #24;
        for (int i = 15; i > 15 - n; i--) begin
            o_sdi = tx[i];
            #24 o_sclk = 1'b1;
            rx = {rx[14:0], i_sdo};
            #24 o_sclk = 1'b0;
        end
        #24 o_csn = 1'b1;
        o_sdi = ~o_sdi;
        #120;
    endtask : xfer
endmodule : sbc_spi_master_model
`default_nettype wire

// ===== verif/test_sbc_status_register_bank.sv
// Purpose: self-checking bench
// Assumes: reply comes in the next frame
// Notes: every read costs two frames
`timescale 1ns/1ps
`default_nettype none
module test_sbc_status_register_bank;
    localparam A_PER = sbc_regs_pkg::ADDR_CYCLIC_TIMER_PERIOD;
    localparam A_SCR = sbc_regs_pkg::ADDR_SCRATCH_CONFIG_BYTE;
    localparam A_SUP = sbc_regs_pkg::ADDR_SUPPLY_FAULT_STATUS;
    localparam A_TH = sbc_regs_pkg::ADDR_THERMAL_STATUS;
    localparam A_DEV = sbc_regs_pkg::ADDR_DEVICE_FAILURE_STATUS;
    logic mclk, rst_n, soft_rst, restart, sclk, csn, sdi, sdo, sdo_oe;
    logic normal, stop_m, main_on, sec_on, lins_q, wake, wdf, wdok;
    logic failsafe;
    logic [7:0] sup_ev;
    logic [2:0] th_ev, per_sel;
    logic [5:0] dev_ev;
    logic [1:0] fo_cfg;
    logic [15:0] rx;
    int miscompares = 0;
    int cmp_count = 0;
    sbc_status_register_bank u_sbc_status_register_bank (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_soft_reset(soft_rst),
        .i_restart(restart), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_normal_mode(normal),
        .i_stop_mode(stop_m), .i_main_reg_on(main_on),
        .i_second_reg_on(sec_on), .i_lins_quiet(lins_q),
        .i_wake_from_sleep(wake), .i_power_on_event(sup_ev[7]),
        .i_lin_supply_uv(sup_ev[6]), .i_main_reg_ov(sup_ev[5]),
        .i_second_reg_ot(sup_ev[4]), .i_second_reg_uv(sup_ev[3]),
        .i_main_reg_short(sup_ev[2]), .i_main_reg_uv(sup_ev[0]),
        .i_severe_thermal(th_ev[2]), .i_moderate_thermal(th_ev[1]),
        .i_thermal_prewarn(th_ev[0]), .i_reset_pin_clamped(dev_ev[5]),
        .i_failsafe_input_error(dev_ev[4]), .i_watchdog_fail(wdf),
        .i_watchdog_trigger_ok(wdok), .i_fail_outputs_on(dev_ev[0]),
        .o_cyclic_period_select(per_sel), .o_enter_failsafe(failsafe),
        .o_fail_output_config(fo_cfg)
    );
    sbc_spi_master_model u_sbc_spi_master_model (
        .o_sclk(sclk), .o_csn(csn), .o_sdi(sdi), .i_sdo(sdo)
    );
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask : w
    task automatic pulse(ref logic s);
        s = 1'b1;
        w(8);
        s = 1'b0;
    endtask : pulse
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_sbc_spi_master_model.xfer(16, {d, 1'b1, a}, rx);
    endtask : wr
    task automatic rc(input logic [6:0] a, input logic [7:0] exp);
        u_sbc_spi_master_model.xfer(16, {8'h00, 1'b0, a}, rx);
        u_sbc_spi_master_model.xfer(16, {8'h00, 1'b0, a}, rx);
        chk(rx[15:8], exp);
    endtask : rc
    task automatic t_reset;
        rc(A_SUP, 8'h80);
        rc(A_TH, 8'h00);
        rc(A_DEV, 8'h00);
        rc(A_PER, 8'h00);
        rc(A_SCR, 8'h00);
        chk({7'h00, sdo_oe}, 8'h00);
    endtask : t_reset
    task automatic t_period;
        for (int c = 0; c < 7; c++) begin
            wr(A_PER, 8'(c) | 8'hf8);
            rc(A_PER, 8'(c));
            chk({5'h00, per_sel}, 8'(c));
        end
        wr(A_PER, 8'h07);
        rc(A_PER, 8'h06);
    endtask : t_period
    task automatic t_scratch;
        wr(A_SCR, 8'ha5);
        rc(A_SCR, 8'ha5);
        normal = 1'b0;
        wr(A_SCR, 8'h3c);
        rc(A_SCR, 8'ha5);
        stop_m = 1'b1;
        wr(A_SCR, 8'h3c);
        rc(A_SCR, 8'h3c);
        pulse(soft_rst);
        w(8);
        rc(A_SCR, 8'h3c);
        rc(A_PER, 8'h00);
        pulse(restart);
        rc(A_SCR, 8'h3c);
        rc(A_DEV, 8'h40);
        wr(A_DEV, 8'hff);
        rc(A_DEV, 8'h00);
        pulse(wake);
        rc(A_DEV, 8'h80);
        wr(A_DEV, 8'h00);
        normal = 1'b1;
        stop_m = 1'b0;
    endtask : t_scratch
    task automatic t_supply;
        wr(A_SUP, 8'h00);
        rc(A_SUP, 8'h00);
        main_on = 1'b0;
        sec_on = 1'b0;
        lins_q = 1'b1;
        sup_ev = 8'h5d;
        w(8);
        sup_ev = 8'h00;
        rc(A_SUP, 8'h00);
        main_on = 1'b1;
        sec_on = 1'b1;
        lins_q = 1'b0;
        for (int b = 0; b < 8; b++) if (b != 1) begin
            sup_ev = 8'h01 << b;
            w(8);
            sup_ev = 8'h00;
            rc(A_SUP, 8'h01 << b);
            rc(A_SUP, 8'h01 << b);
            wr(A_SUP, 8'h00);
        end
        sup_ev[5] = 1'b1;
        wr(A_SUP, 8'h00);
        sup_ev = 8'h00;
        rc(A_SUP, 8'h20);
        wr(A_SUP, 8'h00);
    endtask : t_supply
    task automatic t_thermal;
        for (int b = 0; b < 3; b++) begin
            th_ev = 3'h1 << b;
            w(8);
            chk({7'h00, failsafe}, {7'h00, b == 2});
            th_ev = 3'h0;
            rc(A_TH, 8'h01 << b);
            wr(A_TH, 8'hff);
            rc(A_TH, 8'h00);
        end
    endtask : t_thermal
    task automatic t_device;
        for (int b = 0; b < 6; b++) if (b == 0 || b >= 4) begin
            dev_ev = 6'h01 << b;
            w(8);
            dev_ev = 6'h00;
            rc(A_DEV, 8'h01 << b);
            wr(A_DEV, 8'h00);
        end
        for (int k = 1; k < 4; k++) begin
            pulse(wdf);
            rc(A_DEV, k == 1 ? 8'h04 : 8'h08);
            chk({6'h00, fo_cfg}, k == 1 ? 8'h01 : 8'h03);
        end
        wr(A_DEV, 8'h00);
        rc(A_DEV, 8'h08);
        pulse(wdok);
        rc(A_DEV, 8'h00);
        chk({6'h00, fo_cfg}, 8'h00);
    endtask : t_device
    task automatic t_invalid;
        wr(A_PER, 8'h02);
        u_sbc_spi_master_model.xfer(12, {8'h05, 1'b1, A_PER}, rx);
        rc(A_PER, 8'h02);
        rc(A_DEV, 8'h02);
        wr(A_DEV, 8'h00);
        u_sbc_spi_master_model.xfer(16, {8'h00, 1'b0, 7'h7f}, rx);
        rc(A_DEV, 8'h02);
    endtask : t_invalid
    initial begin
        {rst_n, soft_rst, restart, stop_m, lins_q, wake, wdf, wdok} = 8'h00;
        {normal, main_on, sec_on} = 3'h7;
        {sup_ev, th_ev, dev_ev} = 17'h00000;
        w(10);
        rst_n = 1'b1;
        w(4);
        t_reset();
        t_period();
        t_scratch();
        t_supply();
        t_thermal();
        t_device();
        t_invalid();
        close_out();
    end
    initial begin
        #300000;
        miscompares++;
        close_out();
    end
endmodule : test_sbc_status_register_bank
bind sbc_status_register_bank sbc_status_register_bank_properties u_props (
    .i_mclk, .i_rst_n, .i_csn, .i_severe_thermal, .i_watchdog_fail,
    .i_watchdog_trigger_ok, .o_cyclic_period_select, .o_enter_failsafe,
    .o_fail_output_config
);
`default_nettype wire
